// ===== inc/ssrx_pkg.sv
// Constants and types for the three-wire serial slave receiver
// Function
// R01: Three-wire link: clock and data only, no select
// R02: Full-duplex slave; each frame frees dummy transmit slot
// R03: Sample data on even (rising) clock edges
// R04: Master idles the serial clock high
// R05: Raise receive-full event per latched frame
// R06: Error raises error event, ends serial operation
// R07: Ending operation clears ordinary status flags
// R08: Mode-fault and overrun flags survive operation end
// R09: Error flag clears by zero-write after read-as-one
// R10: Parity disabled: no parity bit, no check
// R11: Eight-bit frames, most significant bit first; lsb_first_select also accepts lsb-first frames, mirrored into rx_data
// R12: Frame completing over unread data sets overrun
package ssrx_pkg;

    // ************************************************************
    // Frame format
    // ************************************************************
    localparam int SSRX_FRAME_BITS = 8;
    localparam logic [3:0] SSRX_FRAME_LENGTH_8 = 4'h7;
    localparam logic [2:0] SSRX_BIT_COUNT_RESET = 3'h0;
    localparam logic [2:0] SSRX_BIT_COUNT_LAST = 3'h7;
    localparam logic [7:0] SSRX_DATA_RESET = 8'h00;

    // ************************************************************
    // Carriers
    // ************************************************************
    typedef struct packed {
        logic interface_enable;
        logic master_select;
        logic three_wire_select;
        logic transmit_only_select;
        logic parity_enable;
        logic lsb_first_select;
        logic [3:0] frame_length_field;
    } ssrx_config_type;

    typedef struct packed {
        logic mode_fault_flag;
        logic overrun_flag;
    } ssrx_error_type;

    localparam ssrx_error_type SSRX_ERROR_RESET = '{1'b0, 1'b0};

    typedef enum logic [1:0] {
        SSRX_IDLE,
        SSRX_RUN,
        SSRX_HALT
    } ssrx_state_type;

endpackage

// ===== core/ssrx_receiver.sv
// Three-wire serial slave receiver, serial-clock and system-clock domains
`timescale 1ns/10ps
module ssrx_receiver (
    // System clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Link pins
    input wire logic serial_clock_pin,
    input wire logic mosi_pin,
    // Configuration
    input ssrx_pkg::ssrx_config_type config_in,
    // Software access
    input wire logic rx_read,
    input wire logic status_read,
    input wire logic status_write,
    input ssrx_pkg::ssrx_error_type status_write_data,
    // Status and data
    output logic [7:0] rx_data,
    output logic receive_full_flag,
    output ssrx_pkg::ssrx_error_type error_flags,
    output logic running,
    // Events
    output logic receive_full_event,
    output logic transmit_empty_event,
    output logic error_event
);
    import ssrx_pkg::*;

    // ************************************************************
    // System-domain state
    // ************************************************************
    ssrx_state_type state;
    logic link_reset_n;
    logic bad_config;
    logic [2:0] frame_sync;
    logic frame_done;
    logic [7:0] link_data_sys;
    ssrx_error_type seen_set;
    logic overrun_now;
    logic mode_fault_now;

    // Lsb-first frames are mirrored so rx_data always holds the msb on the left
    function automatic logic [7:0] bit_reverse(input logic [7:0] value);
        for (int i = 0; i < 8; i++) begin
            bit_reverse[i] = value[7 - i];
        end
    endfunction

    // Only three-wire, full-duplex, 8-bit, no-parity slave use is supported
    assign bad_config = config_in.master_select || !config_in.three_wire_select // [R01]
        || config_in.transmit_only_select // [R02]
        || config_in.parity_enable // [R10]
        || (config_in.frame_length_field != SSRX_FRAME_LENGTH_8); // [R11]

    assign running = (state == SSRX_RUN);
    assign frame_done = frame_sync[2] ^ frame_sync[1];
    assign overrun_now = running && frame_done && receive_full_flag && !rx_read; // [R12]
    assign mode_fault_now = (state == SSRX_IDLE) && config_in.interface_enable && bad_config;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= SSRX_IDLE;
        end else begin
            unique case (state)
                SSRX_IDLE: begin
                    if (config_in.interface_enable) begin
                        state <= bad_config ? SSRX_HALT : SSRX_RUN;
                    end
                end
                SSRX_RUN: begin
                    if (!config_in.interface_enable) begin
                        state <= SSRX_IDLE;
                    end else if (overrun_now) begin
                        state <= SSRX_HALT; // [R06]
                    end
                end
                SSRX_HALT: begin
                    // Stays stopped until software drops the enable
                    if (!config_in.interface_enable) begin
                        state <= SSRX_IDLE;
                    end
                end
                // The unused fourth code falls back to idle rather than locking up
                default: begin
                    state <= SSRX_IDLE;
                end
            endcase
        end
    end

    // Link logic is held cleared whenever the receiver is not running
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            link_reset_n <= 1'b0;
        end else begin
            link_reset_n <= (state == SSRX_RUN) && !overrun_now;
        end
    end

    // ************************************************************
    // Link domain: shift on rising serial clock
    // ************************************************************
    logic [2:0] bit_count;
    logic [6:0] shift;
    logic [7:0] link_data;
    logic frame_toggle;

    // Idle clock is high, so the first edge of a frame falls and the
    // second rises; rising edges are the even, sampling edges
    always_ff @(posedge serial_clock_pin or negedge link_reset_n) begin // [R03] [R04]
        if (!link_reset_n) begin
            bit_count <= SSRX_BIT_COUNT_RESET;
            shift <= 7'h00;
        end else begin
            bit_count <= bit_count + 3'h1;
            shift <= {shift[5:0], mosi_pin}; // [R11]
        end
    end

    always_ff @(posedge serial_clock_pin or negedge link_reset_n) begin
        if (!link_reset_n) begin
            link_data <= SSRX_DATA_RESET;
            frame_toggle <= 1'b0;
        end else if (bit_count == SSRX_BIT_COUNT_LAST) begin
            link_data <= {shift, mosi_pin};
            frame_toggle <= !frame_toggle;
        end
    end

    // ************************************************************
    // Crossing: toggle synchroniser; data is stable a whole frame
    // ************************************************************
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            frame_sync <= 3'h0;
        end else if (!link_reset_n) begin
            frame_sync <= 3'h0;
        end else begin
            frame_sync <= {frame_sync[1:0], frame_toggle};
        end
    end

    // Link data holds for seven more serial clocks after the toggle
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            link_data_sys <= SSRX_DATA_RESET;
        end else begin
            link_data_sys <= link_data;
        end
    end

    // ************************************************************
    // Receive data and receive-full flag
    // ************************************************************
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_data <= SSRX_DATA_RESET;
        end else if (running && frame_done && !overrun_now) begin
            rx_data <= config_in.lsb_first_select ? bit_reverse(link_data_sys) : link_data_sys;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            receive_full_flag <= 1'b0;
        end else if (!running) begin
            receive_full_flag <= 1'b0; // [R07]
        end else if (frame_done && !overrun_now) begin
            receive_full_flag <= 1'b1; // [R05]
        end else if (rx_read) begin
            receive_full_flag <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            receive_full_event <= 1'b0;
            transmit_empty_event <= 1'b0;
        end else begin
            receive_full_event <= running && frame_done && !overrun_now; // [R05]
            transmit_empty_event <= running && frame_done; // [R02]
        end
    end

    // ************************************************************
    // Error flags: survive disable, cleared by read-one-then-write-zero
    // ************************************************************
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            seen_set <= SSRX_ERROR_RESET;
        end else if (status_read) begin
            seen_set <= error_flags; // [R09]
        end else if (status_write) begin
            seen_set <= SSRX_ERROR_RESET;
        end
    end

    // Set wins over a clear in the same cycle
    always_ff @(posedge sys_clk or negedge reset_n) begin // [R08]
        if (!reset_n) begin
            error_flags <= SSRX_ERROR_RESET;
        end else begin
            if (mode_fault_now) begin
                error_flags.mode_fault_flag <= 1'b1;
            end else if (status_write && !status_write_data.mode_fault_flag
                         && seen_set.mode_fault_flag) begin
                error_flags.mode_fault_flag <= 1'b0; // [R09]
            end
            if (overrun_now) begin
                error_flags.overrun_flag <= 1'b1; // [R12]
            end else if (status_write && !status_write_data.overrun_flag
                         && seen_set.overrun_flag) begin
                error_flags.overrun_flag <= 1'b0; // [R09]
            end
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            error_event <= 1'b0;
        end else begin
            error_event <= overrun_now || mode_fault_now; // [R06]
        end
    end

endmodule

// ===== tb/ssrx_master_model.sv
// Serial master model: idle-high clock, data launched on falling edges
`timescale 1ns/10ps
module ssrx_master_model (
    // Link pins
    output logic serial_clock_pin,
    output logic mosi_pin
);
    initial begin
        serial_clock_pin = 1'b1;
        mosi_pin = 1'b0;
    end
    // Only clock and data exist; bits pair into bytes by count alone
    task automatic send(input logic [7:0] value);
        for (int i = 7; i >= 0; i--) begin
            #62.5 serial_clock_pin = 1'b0;
            mosi_pin = value[i];
            #62.5 serial_clock_pin = 1'b1;
        end
        // Hold briefly, then show the inverse so a late sample cannot pass
        #10 mosi_pin = ~value[0];
    endtask
endmodule

// ===== tb/ssrx_receiver_sva.sv
// Checker for the serial receiver status and event ports
`timescale 1ns/10ps
module ssrx_receiver_sva (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Software access
    input wire logic status_read,
    input wire logic status_write,
    // Status and events
    input wire logic receive_full_flag,
    input ssrx_pkg::ssrx_error_type error_flags,
    input wire logic running,
    input wire logic receive_full_event,
    input wire logic transmit_empty_event,
    input wire logic error_event
);
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);
    sequence frame_done_s;
        receive_full_event ##0 receive_full_flag;
    endsequence
    tx_pair_a: assert property (receive_full_event |-> transmit_empty_event)
        else $error("dummy transmit slot missing");
    full_flag_a: assert property (frame_done_s |=> !receive_full_event)
        else $error("receive event not a single pulse with flag");
    err_stop_a: assert property (error_event |-> ##[0:2] !running)
        else $error("error did not stop operation");
    mf_halt_a: assert property ($rose(error_flags.mode_fault_flag) |-> ##[0:1] !running)
        else $error("mode fault left link running");
    end_clear_a: assert property ($fell(running) |-> ##[0:2] !receive_full_flag)
        else $error("receive flag kept after end");
    flag_keep_a: assert property (!status_write |=>
        (error_flags & $past(error_flags)) == $past(error_flags))
        else $error("error flag dropped without write");
    clear_read_a: assert property (|($past(error_flags) & ~error_flags) |->
        $past(status_write) && $past(status_read, 2))
        else $error("error flag cleared without read");
    ovr_err_a: assert property ($rose(error_flags.overrun_flag) |->
        error_event || $past(error_event))
        else $error("overrun without error event");
endmodule

// ===== tb/ssrx_receiver_tb_top.sv
// Top testbench of the serial slave receiver
`timescale 1ns/10ps
module ssrx_receiver_tb_top;
    import ssrx_pkg::*;
    logic sys_clk, reset_n, serial_clock_pin, mosi_pin, rx_read, status_read, status_write;
    logic receive_full_flag, running, receive_full_event, transmit_empty_event, error_event;
    logic [7:0] rx_data, b;
    logic seen;
    ssrx_config_type config_in;
    ssrx_error_type status_write_data, error_flags;
    int fails, n_tests;
    ssrx_master_model u_ssrx_master_model (.serial_clock_pin(serial_clock_pin),
        .mosi_pin(mosi_pin));
    ssrx_receiver u_ssrx_receiver (.sys_clk(sys_clk), .reset_n(reset_n),
        .serial_clock_pin(serial_clock_pin), .mosi_pin(mosi_pin), .config_in(config_in),
        .rx_read(rx_read), .status_read(status_read), .status_write(status_write),
        .status_write_data(status_write_data), .rx_data(rx_data),
        .receive_full_flag(receive_full_flag), .error_flags(error_flags), .running(running),
        .receive_full_event(receive_full_event), .transmit_empty_event(transmit_empty_event),
        .error_event(error_event));
    // ****************************************
    // Helpers
    // ****************************************
    function automatic ssrx_config_type cfg(input int bad);
        cfg = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, SSRX_FRAME_LENGTH_8};
        if (bad == 1) cfg.master_select = 1'b1;
        if (bad == 2) cfg.three_wire_select = 1'b0;
        if (bad == 3) cfg.transmit_only_select = 1'b1;
        if (bad == 4) cfg.parity_enable = 1'b1;
        if (bad == 5) cfg.frame_length_field = 4'h3;
    endfunction
    function automatic logic [7:0] rev8(input logic [7:0] v);
        rev8 = {v[0], v[1], v[2], v[3], v[4], v[5], v[6], v[7]};
    endfunction
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: saw %h want %h", $time, got, exp);
        end
    endtask
    // Called on an edge: 0 reads data, 1 reads status, 2 writes status
    task automatic pulse(input int sel);
        rx_read <= (sel == 0);
        status_read <= (sel == 1);
        status_write <= (sel == 2);
        @(posedge sys_clk);
        {rx_read, status_read, status_write} <= 3'h0;
    endtask
    // Status read then status write on consecutive edges, each strobe set once
    task automatic rd_wr;
        status_read <= 1'b1;
        @(posedge sys_clk);
        status_read <= 1'b0;
        status_write <= 1'b1;
        @(posedge sys_clk);
        status_write <= 1'b0;
    endtask
    task automatic wait_evt(output logic hit);
        hit = 1'b0;
        for (int i = 0; i < 400 && !hit; i++) begin
            @(posedge sys_clk);
            #1 hit = (receive_full_event === 1'b1);
        end
    endtask
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    // Whole run is about seven frames of 1 us each; allow about twenty-eight times that
    initial begin
        #200000;
        fails++;
        test_done;
    end
    initial begin
        void'($urandom(32'h3edb));
        {reset_n, rx_read, status_read, status_write} = 4'h0;
        config_in = '0;
        status_write_data = '0;
        repeat (20) @(posedge sys_clk);
        reset_n <= 1'b1;
        @(posedge sys_clk);
        config_in <= cfg(0);
        repeat (4) @(posedge sys_clk);
        #1 check(8'({running, receive_full_flag, error_flags}), 8'h8);
        for (int k = 0; k < 5; k++) begin
            b = (k == 0) ? 8'h80 : 8'($urandom);
            @(posedge sys_clk);
            config_in.lsb_first_select <= (k == 3);
            fork
                u_ssrx_master_model.send(b);
                wait_evt(seen);
            join
            check(8'({seen, transmit_empty_event, receive_full_flag}), 8'h7);
            check(rx_data, (k == 3) ? rev8(b) : b);
            @(posedge sys_clk);
            pulse(0);
            #1 check(8'(receive_full_flag), 8'h0);
        end
        fork
            u_ssrx_master_model.send(8'h5a);
            wait_evt(seen);
        join
        u_ssrx_master_model.send(8'ha5);
        repeat (12) @(posedge sys_clk);
        #1 check(8'({error_flags, running, receive_full_flag}), 8'h4);
        check(rx_data, 8'h5a);
        @(posedge sys_clk);
        config_in.interface_enable <= 1'b0;
        repeat (3) @(posedge sys_clk);
        #1 check(8'(error_flags), 8'h1);
        @(posedge sys_clk);
        pulse(2);
        #1 check(8'(error_flags), 8'h1);
        @(posedge sys_clk);
        rd_wr;
        #1 check(8'(error_flags), 8'h0);
        for (int m = 1; m <= 5; m++) begin
            @(posedge sys_clk);
            config_in <= cfg(m);
            repeat (3) @(posedge sys_clk);
            #1 check(8'({error_flags, running}), 8'h4);
            @(posedge sys_clk);
            config_in <= '0;
            rd_wr;
        end
        #1 check(8'(error_flags), 8'h0);
        test_done;
    end
endmodule
bind ssrx_receiver ssrx_receiver_sva u_ssrx_receiver_sva (.sys_clk(sys_clk),
    .reset_n(reset_n), .status_read(status_read), .status_write(status_write),
    .receive_full_flag(receive_full_flag), .error_flags(error_flags), .running(running),
    .receive_full_event(receive_full_event), .transmit_empty_event(transmit_empty_event),
    .error_event(error_event));
